// [shared/motion_pkg.sv]
// Constants for the motion wake and rest detector
// Assumes an APB slave at 50 MHz with word-aligned registers
`default_nettype none
package motion_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_THRESHOLD = 8'h04;
	localparam logic [7:0] OFF_DURATION = 8'h08;
	localparam logic [7:0] OFF_PIN1_ROUTE = 8'h0c;
	localparam logic [7:0] OFF_PIN2_ROUTE = 8'h10;
	localparam logic [7:0] OFF_MOTION_SRC = 8'h14;
	localparam logic [7:0] OFF_COMBINED_SRC = 8'h18;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_ENABLE = 7;
	localparam int CTL_LATCH = 4;
	localparam int CTL_PIN_STATE = 5;
	localparam int CTL_FILTER = 0;
	// ----------------------------------------
	// Threshold and duration fields
	// ----------------------------------------
	localparam int THS_MSB = 5;
	localparam int DUR_WEIGHT = 4;
	localparam int DUR_ACT_LSB = 5;
	localparam int DUR_INACT_MSB = 3;
	// ----------------------------------------
	// Route register fields
	// ----------------------------------------
	localparam int ROUTE_CHANGE = 7;
	localparam int ROUTE_WAKE = 5;
	// ----------------------------------------
	// Source register fields
	// ----------------------------------------
	localparam int SRC_CHANGE = 6;
	localparam int SRC_WAKE = 3;
	localparam int SRC_REST = 4;
	// ----------------------------------------
	// Timing in samples, threshold weight shifts and reset value
	// ----------------------------------------
	localparam int INACT_UNIT = 512;
	localparam int INACT_ZERO = 16;
	localparam int WEIGHT_COARSE_SHIFT = 6;
	localparam int WEIGHT_FINE_SHIFT = 8;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage : motion_pkg
`default_nettype wire

// [design/motion_detector.sv]
// Motion wake and rest detector with APB register file
// Assumes sample strobe and axis data arrive on pclk from the filter front end
//
// The register addresses and the APB register port were left to the implementer.
`default_nettype none
module motion_detector
	import motion_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sample input
	input wire logic sample_valid,
	input wire logic [3*DATA_W-1:0] raw_xyz,
	input wire logic [3*DATA_W-1:0] hp_xyz,
	input wire logic [1:0] full_scale,
	// Interrupt pins
	output logic irq_pin_one,
	output logic irq_pin_two
);
	localparam int CNT_W = 14;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] control, threshold_config, duration_config;
	logic [7:0] pin1_function_route, pin2_function_route;
	logic [DATA_W-1:0] prev_xyz [3];
	logic [2:0] axis_over;
	logic wake, change_flag, current_rest_state, latched_change, latched_wake;
	logic [1:0] act_count;
	logic [CNT_W-1:0] rest_count;
	logic read_src, wr;

	wire logic enable = control[CTL_ENABLE];
	wire logic route_change = pin1_function_route[ROUTE_CHANGE] | pin2_function_route[ROUTE_CHANGE];
	wire logic route_wake = pin1_function_route[ROUTE_WAKE] | pin2_function_route[ROUTE_WAKE];
	wire logic latch_chg = control[CTL_LATCH] & route_change & ~control[CTL_PIN_STATE];
	wire logic latch_wk = control[CTL_LATCH] & route_wake;
	wire logic [1:0] activity_duration = duration_config[DUR_ACT_LSB+1:DUR_ACT_LSB];
	wire logic [3:0] inactivity_duration = duration_config[DUR_INACT_MSB:0];

	// Absolute value of a signed axis word
	function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v);
		magnitude = v[DATA_W-1] ? DATA_W'(-v) : v;
	endfunction : magnitude

	// Threshold scaled to data LSBs
	function automatic logic [DATA_W-1:0] scaled_threshold(input logic [5:0] t, input logic w);
		logic [DATA_W-1:0] base;
		base = DATA_W'(t) << (DATA_W - 1 - (w ? WEIGHT_FINE_SHIFT : WEIGHT_COARSE_SHIFT));
		scaled_threshold = base;
	endfunction : scaled_threshold

	wire logic [DATA_W-1:0] ths = scaled_threshold(threshold_config[THS_MSB:0], duration_config[DUR_WEIGHT]);

	// ----------------------------------------
	// Filter and compare
	// ----------------------------------------
	logic [2:0] next_over;
	always_comb begin
		logic [DATA_W:0] diff;
		logic [DATA_W-1:0] f;
		diff = '0;
		f = '0;
		next_over = '0;
		for (int a = 0; a < 3; a++) begin
			diff = {raw_xyz[a*DATA_W+DATA_W-1], raw_xyz[a*DATA_W +: DATA_W]}
				- {prev_xyz[a][DATA_W-1], prev_xyz[a]};
			f = control[CTL_FILTER] ? hp_xyz[a*DATA_W +: DATA_W] : diff[DATA_W:1];
			next_over[a] = magnitude(f) > ths;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int a = 0; a < 3; a++) prev_xyz[a] <= '0;
			axis_over <= '0;
		end else if (!enable) begin
			for (int a = 0; a < 3; a++) prev_xyz[a] <= '0;
			axis_over <= '0;
		end else if (sample_valid) begin
			for (int a = 0; a < 3; a++) prev_xyz[a] <= raw_xyz[a*DATA_W +: DATA_W];
			axis_over <= next_over;
		end
	end

	// ----------------------------------------
	// Activity and inactivity state
	// ----------------------------------------
	wire logic any_over = |next_over;
	wire logic [CNT_W-1:0] rest_target = (inactivity_duration == 4'h0) ? CNT_W'(INACT_ZERO)
		: CNT_W'(INACT_UNIT) * CNT_W'(inactivity_duration);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_count <= '0;
			rest_count <= '0;
			current_rest_state <= 1'b0;
			change_flag <= 1'b0;
			wake <= 1'b0;
		end else if (!enable) begin
			act_count <= '0;
			rest_count <= '0;
			current_rest_state <= 1'b0;
			change_flag <= 1'b0;
			wake <= 1'b0;
		end else if (sample_valid) begin
			change_flag <= 1'b0;
			if (any_over) begin
				rest_count <= '0;
				wake <= (act_count >= activity_duration);
				if (act_count < activity_duration) act_count <= act_count + 2'd1;
				if (current_rest_state && act_count >= activity_duration) begin
					current_rest_state <= 1'b0;
					change_flag <= 1'b1;
				end
			end else begin
				act_count <= '0;
				wake <= 1'b0;
				if (rest_count + CNT_W'(1) >= rest_target && !current_rest_state) begin
					current_rest_state <= 1'b1;
					change_flag <= 1'b1;
				end
				if (rest_count < rest_target) rest_count <= rest_count + CNT_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Latching, released on source read at next sample
	// ----------------------------------------
	logic read_pending;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_change <= 1'b0;
			latched_wake <= 1'b0;
			read_pending <= 1'b0;
		end else if (!enable) begin
			latched_change <= 1'b0;
			latched_wake <= 1'b0;
			read_pending <= 1'b0;
		end else begin
			if (read_src) read_pending <= 1'b1;
			else if (sample_valid) read_pending <= 1'b0;
			if (change_flag && latch_chg) latched_change <= 1'b1;
			else if (sample_valid && (read_pending || read_src)) latched_change <= 1'b0;
			if (wake && latch_wk) latched_wake <= 1'b1;
			else if (sample_valid && (read_pending || read_src)) latched_wake <= 1'b0;
		end
	end

	wire logic change_seen = change_flag | (latch_chg & latched_change);
	wire logic wake_seen = wake | (latch_wk & latched_wake);
	wire logic pin_change = control[CTL_PIN_STATE] ? current_rest_state : change_seen;

	// ----------------------------------------
	// Interrupt pins
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_one <= 1'b0;
			irq_pin_two <= 1'b0;
		end else begin
			irq_pin_one <= enable & ((pin1_function_route[ROUTE_CHANGE] & pin_change)
				| (pin1_function_route[ROUTE_WAKE] & wake_seen));
			irq_pin_two <= enable & ((pin2_function_route[ROUTE_CHANGE] & pin_change)
				| (pin2_function_route[ROUTE_WAKE] & wake_seen));
		end
	end

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign wr = psel & penable & pwrite;
	assign read_src = psel & penable & ~pwrite & (paddr == OFF_MOTION_SRC || paddr == OFF_COMBINED_SRC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control <= RESET_ZERO[7:0];
			threshold_config <= RESET_ZERO[7:0];
			duration_config <= RESET_ZERO[7:0];
			pin1_function_route <= RESET_ZERO[7:0];
			pin2_function_route <= RESET_ZERO[7:0];
		end else if (wr) begin
			case (paddr)
				OFF_CONTROL: control <= pwdata[7:0];
				OFF_THRESHOLD: threshold_config <= pwdata[7:0];
				OFF_DURATION: duration_config <= pwdata[7:0];
				OFF_PIN1_ROUTE: pin1_function_route <= pwdata[7:0];
				OFF_PIN2_ROUTE: pin2_function_route <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	logic [31:0] next_rdata;
	logic bad_addr;
	always_comb begin
		next_rdata = '0;
		bad_addr = 1'b0;
		case (paddr)
			OFF_CONTROL: next_rdata[7:0] = control;
			OFF_THRESHOLD: next_rdata[7:0] = threshold_config;
			OFF_DURATION: next_rdata[7:0] = duration_config;
			OFF_PIN1_ROUTE: next_rdata[7:0] = pin1_function_route;
			OFF_PIN2_ROUTE: next_rdata[7:0] = pin2_function_route;
			OFF_MOTION_SRC: begin
				next_rdata[SRC_CHANGE] = change_seen;
				next_rdata[SRC_WAKE] = wake_seen;
				next_rdata[SRC_REST] = current_rest_state;
				next_rdata[2:0] = axis_over;
			end
			OFF_COMBINED_SRC: begin
				next_rdata[SRC_CHANGE] = change_seen;
				next_rdata[SRC_WAKE] = wake_seen;
			end
			default: bad_addr = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & bad_addr;
			if (psel && !penable && !pwrite) prdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_change_one_sample: assert property (@(posedge pclk) disable iff (!presetn)
		enable && change_flag && !sample_valid |=> change_flag) else $error("change pulse shortened");
	a_disable_clears: assert property (@(posedge pclk) disable iff (!presetn)
		!enable |=> !change_flag && !wake && rest_count == '0) else $error("state not cleared");
	a_wake_drops: assert property (@(posedge pclk) disable iff (!presetn)
		enable && sample_valid && !any_over |=> !wake) else $error("wake not released");
	a_pin_or: assert property (@(posedge pclk) disable iff (!presetn)
		enable && pin1_function_route[ROUTE_WAKE] && wake |=> irq_pin_one) else $error("pin not set");
	a_state_on_pin: assert property (@(posedge pclk) disable iff (!presetn)
		enable && control[CTL_PIN_STATE] && pin1_function_route[ROUTE_CHANGE] && current_rest_state
		|=> irq_pin_one) else $error("state not on pin");
	a_zero_dur_wake: assert property (@(posedge pclk) disable iff (!presetn)
		enable && sample_valid && any_over && activity_duration == 2'd0 |=> wake)
		else $error("wake missed");
	sequence s_quiet_sample;
		enable && sample_valid && !any_over;
	endsequence
	sequence s_unlatched_change;
		enable && !latch_chg && change_flag;
	endsequence
	a_pulse_no_latch: assert property (@(posedge pclk) disable iff (!presetn)
		s_unlatched_change ##0 s_quiet_sample |=> !change_seen) else $error("unlatched flag held");
	a_short_rest: assert property (@(posedge pclk) disable iff (!presetn)
		s_quiet_sample ##0 (inactivity_duration == 4'h0 && !current_rest_state
		&& rest_count == CNT_W'(INACT_ZERO - 1)) |=> current_rest_state && change_flag)
		else $error("rest entry missed");
	a_latch_release: assert property (@(posedge pclk) disable iff (!presetn)
		enable && sample_valid && read_pending && !change_flag && !wake |=> !latched_change && !latched_wake)
		else $error("latch not released");
	a_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!enable |=> !irq_pin_one && !irq_pin_two) else $error("pin active while disabled");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		enable && latch_chg && latched_change && !sample_valid |=> latched_change)
		else $error("latch lost");
endmodule : motion_detector
`default_nettype wire

// [dv/apb_host.sv]
// Host model: APB master tasks the bench calls for register access
// Assumes one clock pclk; waits for pready as long as it takes, the bench watchdog ends a hang
`default_nettype none
module apb_host (
	// Clock
	input wire logic pclk,
	// APB master
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [7:0] paddr,
	output var logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// Called just after a rising edge; returns just after one
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd
	// Configure first, route the wake event to pin one last
	task automatic wake_setup(input logic [31:0] ctl, input logic [31:0] thr, input logic [31:0] dur);
		wr(8'h00, ctl);
		wr(8'h04, thr);
		wr(8'h08, dur);
		wr(8'h0c, 32'h0000_0020);
	endtask : wake_setup
endmodule : apb_host
`default_nettype wire

// [dv/tb.sv]
// Bench for the motion wake and rest detector
// Assumes the host model drives APB and the bench drives the samples
`default_nettype none
module tb
	import motion_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [15:0] v;
		logic w;
		logic exp;
	} row_t;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sample_valid;
	logic [47:0] raw_xyz;
	logic [47:0] hp_xyz;
	logic irq_pin_one;
	logic irq_pin_two;
	logic [31:0] q;
	logic e;
	int bad_count;
	int n_compared;
	int hits;
	int first;
	row_t rows [8];
	motion_detector dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .raw_xyz(raw_xyz), .hp_xyz(hp_xyz), .full_scale(2'b00),
		.irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
	apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic samp(input logic [15:0] v);
		sample_valid <= 1'b1;
		raw_xyz <= {32'h0000_0000, v};
		hp_xyz <= {32'h0000_0000, v};
		@(posedge pclk);
		sample_valid <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : samp
	// Quiet samples; count change pulses seen on pin two
	task automatic rest_run(input int n);
		hits = 0;
		first = 0;
		for (int k = 1; k <= n; k++) begin
			samp(16'h0000);
			if (irq_pin_two === 1'b1) begin
				hits++;
				if (first == 0)
					first = k;
			end
		end
	endtask : rest_run
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		wrap_up();
	end
	initial begin
		presetn = 1'b0;
		sample_valid = 1'b0;
		raw_xyz = '0;
		hp_xyz = '0;
		bad_count = 0;
		n_compared = 0;
		rows = '{'{16'h0401, 1'b0, 1'b1}, '{16'h0401, 1'b0, 1'b1}, '{16'h0400, 1'b0, 1'b0},
			'{16'hfbff, 1'b0, 1'b1}, '{16'hfc00, 1'b0, 1'b0}, '{16'h0101, 1'b1, 1'b1},
			'{16'h0100, 1'b1, 1'b0}, '{16'h0000, 1'b0, 1'b0}};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(irq_pin_one | irq_pin_two), 32'h0);
		host.rd(OFF_CONTROL, q, e);
		chk(q, RESET_ZERO);
		host.rd(8'h1c, q, e);
		chk({q[30:0], e}, 32'h1);
		// Table of wake cases on the high-pass input
		host.wake_setup(32'h81, 32'h02, 32'h00);
		foreach (rows[i]) begin
			host.wr(OFF_DURATION, {27'h0, rows[i].w, 4'h0});
			samp(rows[i].v);
			chk(32'(irq_pin_one), 32'(rows[i].exp));
		end
		// Rest detection, short and long durations
		host.wr(OFF_PIN2_ROUTE, 32'h80);
		host.wr(OFF_CONTROL, 32'h01);
		host.wr(OFF_CONTROL, 32'h81);
		rest_run(20);
		chk(32'(hits), 32'h1);
		chk(32'(first >= 16 && first <= 17), 32'h1);
		host.rd(OFF_MOTION_SRC, q, e);
		chk(32'(q[SRC_REST]), 32'h1);
		chk(32'(q[SRC_CHANGE]), 32'h0);
		host.wr(OFF_DURATION, 32'h01);
		host.wr(OFF_CONTROL, 32'h01);
		host.wr(OFF_CONTROL, 32'h81);
		rest_run(520);
		chk(32'(hits), 32'h1);
		chk(32'(first >= 512 && first <= 513), 32'h1);
		// Pin carries the rest state
		host.wr(OFF_CONTROL, 32'ha1);
		samp(16'h0000);
		chk(32'(irq_pin_two), 32'h1);
		samp(16'h0401);
		chk(32'(irq_pin_two), 32'h0);
		host.rd(OFF_MOTION_SRC, q, e);
		chk(32'(q[SRC_REST]), 32'h0);
		// Activity needs two samples over threshold
		host.wr(OFF_CONTROL, 32'h81);
		host.wr(OFF_DURATION, 32'h00);
		rest_run(18);
		host.wr(OFF_DURATION, 32'h20);
		samp(16'h0401);
		chk(32'(irq_pin_two), 32'h0);
		samp(16'h0401);
		chk(32'(irq_pin_two), 32'h1);
		host.rd(OFF_COMBINED_SRC, q, e);
		chk(32'(q[SRC_CHANGE]), 32'h1);
		samp(16'h0401);
		chk(32'(irq_pin_two), 32'h0);
		// Latched wake, also OR-ed onto pin two
		host.wr(OFF_DURATION, 32'h00);
		host.wr(OFF_PIN2_ROUTE, 32'ha0);
		host.wr(OFF_CONTROL, 32'h91);
		samp(16'h0401);
		chk(32'(irq_pin_two), 32'h1);
		samp(16'h0000);
		chk(32'(irq_pin_one), 32'h1);
		host.rd(OFF_MOTION_SRC, q, e);
		chk(32'(q[SRC_WAKE]), 32'h1);
		samp(16'h0000);
		chk(32'(irq_pin_one), 32'h0);
		// Latched change held on pin two until a source read
		rest_run(18);
		chk(32'(irq_pin_two), 32'h1);
		host.rd(OFF_COMBINED_SRC, q, e);
		chk(32'(q[SRC_CHANGE]), 32'h1);
		samp(16'h0000);
		chk(32'(irq_pin_two), 32'h0);
		// Detection disabled
		host.wr(OFF_CONTROL, 32'h11);
		samp(16'h0401);
		chk(32'(irq_pin_one | irq_pin_two), 32'h0);
		// Slope filter; first wake after enable is the settling artefact to ignore
		host.wr(OFF_CONTROL, 32'h80);
		samp(16'h0fa0);
		chk(32'(irq_pin_one), 32'h1);
		samp(16'h0fa0);
		chk(32'(irq_pin_one), 32'h0);
		samp(16'h079e);
		chk(32'(irq_pin_one), 32'h1);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
